// ==== hw/crc_top.sv ====
`timescale 1ns/10ps
module crc_top #(
    parameter int CL_LIMIT = crc_pkg::CL_LIMIT,
    parameter int BLANK_CYCLES = crc_pkg::BLANK_CYCLES,
    parameter int PGD_CYCLES = crc_pkg::PGD_CYCLES
) (
    // Clock, reset, freeze
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Supervisors and analog comparator flags
    input wire logic supply_good_analog,
    input wire logic supply_good_driver,
    input wire logic enable,
    input wire logic fb_over_window,
    input wire logic fb_over_abs,
    input wire logic fb_under_window,
    input wire logic fb_in_window,
    input wire logic over_temp,
    input wire logic over_current,
    input wire logic under_current,
    input wire logic zero_cross,
    input wire logic hs_request,
    input wire logic soft_start_done,
    input wire logic sleep_level_at_supply,
    // Processor side
    input wire logic sleep_request,
    input wire logic [5:0] voltage_code,
    // Power stage
    output logic high_side_gate,
    output logic low_side_gate,
    // Open-drain status pins
    output logic power_good_n_out,
    output logic power_good_n_oe,
    output logic delayed_power_good_out,
    output logic delayed_power_good_oe,
    // Analog control
    output logic [10:0] ref_mv,
    output logic ref_from_sleep_level,
    output logic ref_from_boot,
    output logic [1:0] slew_select,
    output logic hysteresis_set_reduced
);
    if (CL_LIMIT < 1 || CL_LIMIT > 63 || BLANK_CYCLES < 1 || BLANK_CYCLES > 63
        || PGD_CYCLES < 1 || PGD_CYCLES > 1023)
    begin : g_bad_param
        $error("crc_top: counter parameter out of range");
    end

    localparam logic [5:0] CL_LAST = 6'(CL_LIMIT - 1);
    localparam logic [5:0] BLANK_LOAD = 6'(BLANK_CYCLES);
    localparam logic [9:0] PGD_LOAD = 10'(PGD_CYCLES);
    localparam logic [7:0] BOOT_LAST = 8'(crc_pkg::BOOT_CLKS - 1);
    localparam int REF_W = crc_pkg::REF_W;

    logic [crc_pkg::SYNC_W-1:0] raw;
    logic [crc_pkg::SYNC_W-1:0] sync1;
    logic [crc_pkg::SYNC_W-1:0] sync2;
    logic [crc_pkg::SYNC_W-1:0] sync3;
    logic [crc_pkg::SYNC_W-1:0] clean;

    assign raw = {voltage_code, sleep_level_at_supply, sleep_request, soft_start_done, hs_request,
                  zero_cross, under_current, over_current, over_temp, fb_in_window, fb_under_window,
                  fb_over_abs, fb_over_window, enable, supply_good_driver, supply_good_analog};

    // Pins accepted only once the second and third stage agree
    for (genvar i = 0; i < crc_pkg::SYNC_W; i++)
    begin : g_sync
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                sync1[i] <= 1'b0;
                sync2[i] <= 1'b0;
                sync3[i] <= 1'b0;
                clean[i] <= 1'b0;
            end
            else if (ce)
            begin
                sync1[i] <= raw[i];
                sync2[i] <= sync1[i];
                sync3[i] <= sync2[i];
                if (sync2[i] == sync3[i])
                    clean[i] <= sync3[i];
            end
        end
    end

    crc_pkg::crc_state_type state;
    logic sw_enable;
    logic [5:0] code_q;
    logic sleep_q;
    logic code_sleep_mode;
    logic fault_ov;
    logic fault_cl;
    logic fault_hot;
    logic cl_block;
    logic ps_latch;
    logic oc_q;
    logic [5:0] cl_count;
    logic [5:0] blank_cnt;
    logic last_change_sleep;
    logic [7:0] boot_cnt;
    logic pg_seen;
    logic [9:0] pgd_cnt;
    logic next_high_side_gate;
    logic next_low_side_gate;
    logic [5:0] code;
    logic sleep_act;
    logic supplies_ok;
    logic enable_ok;
    logic switching;
    logic change;
    logic transition;
    logic cycle_tick;
    logic ov_now;
    logic cl_now;
    logic pg_int;
    logic dpg_int;
    logic hs_gate_q;

    assign code = clean[crc_pkg::P_CODE +: crc_pkg::CODE_W];
    assign sleep_act = clean[crc_pkg::P_SLEEP];
    assign supplies_ok = clean[crc_pkg::P_SUPPLY_A] & clean[crc_pkg::P_SUPPLY_D];
    assign enable_ok = clean[crc_pkg::P_ENABLE] & sw_enable;
    assign switching = supplies_ok && enable_ok
                       && (state == crc_pkg::ST_SOFT || state == crc_pkg::ST_BOOT || state == crc_pkg::ST_RUN);
    assign change = (code != code_q) || (sleep_act != sleep_q);
    assign transition = change || (blank_cnt != 6'h00);
    assign cycle_tick = high_side_gate && !hs_gate_q;
    assign ov_now = clean[crc_pkg::P_OV_ABS]
                    || (clean[crc_pkg::P_OV_WIN] && state != crc_pkg::ST_SOFT && !transition);
    assign cl_now = clean[crc_pkg::P_OC] && !oc_q && clean[crc_pkg::P_UV_WIN]
                    && state != crc_pkg::ST_SOFT && cl_count == CL_LAST;
    assign pg_int = supplies_ok && enable_ok && state == crc_pkg::ST_RUN
                    && clean[crc_pkg::P_IN_WIN] && !transition;
    assign dpg_int = pg_int && pg_seen && pgd_cnt == PGD_LOAD;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state <= crc_pkg::ST_OFF;
        else if (ce)
        begin
            if (!supplies_ok || !enable_ok)
                state <= crc_pkg::ST_OFF;
            else
            begin
                unique case (state)
                    crc_pkg::ST_OFF:
                        state <= crc_pkg::ST_SOFT;
                    crc_pkg::ST_SOFT:
                        if (ov_now || cl_now || clean[crc_pkg::P_HOT])
                            state <= crc_pkg::ST_FAULT;
                        else if (clean[crc_pkg::P_SS_DONE])
                            state <= crc_pkg::ST_BOOT;
                    crc_pkg::ST_BOOT:
                        if (ov_now || cl_now || clean[crc_pkg::P_HOT])
                            state <= crc_pkg::ST_FAULT;
                        else if (boot_cnt == BOOT_LAST && clean[crc_pkg::P_IN_WIN])
                            state <= crc_pkg::ST_RUN;
                    crc_pkg::ST_RUN:
                        if (ov_now || cl_now || clean[crc_pkg::P_HOT])
                            state <= crc_pkg::ST_FAULT;
                    crc_pkg::ST_FAULT:
                        state <= crc_pkg::ST_FAULT;
                endcase
            end
        end
    end

    // Fault kinds; only leaving the powered, enabled condition clears them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fault_ov <= 1'b0;
            fault_cl <= 1'b0;
            fault_hot <= 1'b0;
        end
        else if (ce)
        begin
            if (!supplies_ok || !enable_ok || state == crc_pkg::ST_OFF)
            begin
                fault_ov <= 1'b0;
                fault_cl <= 1'b0;
                fault_hot <= 1'b0;
            end
            else if (state != crc_pkg::ST_FAULT)
            begin
                fault_ov <= ov_now;
                fault_cl <= cl_now;
                fault_hot <= clean[crc_pkg::P_HOT];
            end
        end
    end

    // Start-up strap: re-sampled every cycle of lockout, frozen once switching starts
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            code_sleep_mode <= 1'b0;
        else if (ce && state == crc_pkg::ST_OFF)
            code_sleep_mode <= clean[crc_pkg::P_STRAP];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cl_block <= 1'b0;
        else if (ce)
        begin
            if (clean[crc_pkg::P_OC])
                cl_block <= 1'b1;
            else if (clean[crc_pkg::P_UC] || !switching)
                cl_block <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            oc_q <= 1'b0;
            cl_count <= 6'h00;
        end
        else if (ce)
        begin
            oc_q <= clean[crc_pkg::P_OC];
            if (!clean[crc_pkg::P_UV_WIN] || state == crc_pkg::ST_SOFT || !switching)
                cl_count <= 6'h00;
            else if (clean[crc_pkg::P_OC] && !oc_q && cl_count != CL_LAST)
                cl_count <= cl_count + 6'h01;
        end
    end

    // A zero crossing in the turn-on cycle wins, so outside an over-voltage fault the low gate never re-enters reverse current
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ps_latch <= 1'b0;
        else if (ce)
        begin
            if (switching && clean[crc_pkg::P_ZC])
                ps_latch <= 1'b1;
            else if ((next_high_side_gate && !high_side_gate) || !switching)
                ps_latch <= 1'b0;
        end
    end

    always_comb
    begin
        next_high_side_gate = switching && clean[crc_pkg::P_HS_REQ] && !cl_block;
        next_low_side_gate = switching && !next_high_side_gate && !ps_latch;
        if (supplies_ok && enable_ok && state == crc_pkg::ST_FAULT)
        begin
            next_high_side_gate = 1'b0;
            next_low_side_gate = fault_ov;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            high_side_gate <= 1'b0;
            low_side_gate <= 1'b0;
            hs_gate_q <= 1'b0;
        end
        else if (ce)
        begin
            high_side_gate <= next_high_side_gate;
            low_side_gate <= next_low_side_gate;
            // Last gate level, so each turn-on counts once as a switching cycle
            hs_gate_q <= high_side_gate;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            code_q <= 6'h00;
            sleep_q <= 1'b0;
            blank_cnt <= 6'h00;
            last_change_sleep <= 1'b0;
        end
        else if (ce)
        begin
            code_q <= code;
            sleep_q <= sleep_act;
            if (change)
            begin
                blank_cnt <= BLANK_LOAD;
                last_change_sleep <= sleep_act != sleep_q;
            end
            else if (cycle_tick && blank_cnt != 6'h00)
                blank_cnt <= blank_cnt - 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            boot_cnt <= 8'h00;
        else if (ce)
        begin
            if (state != crc_pkg::ST_BOOT || !clean[crc_pkg::P_IN_WIN])
                boot_cnt <= 8'h00;
            else if (boot_cnt != BOOT_LAST)
                boot_cnt <= boot_cnt + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pg_seen <= 1'b0;
            pgd_cnt <= 10'h000;
        end
        else if (ce)
        begin
            if (!switching)
            begin
                pg_seen <= 1'b0;
                pgd_cnt <= 10'h000;
            end
            else
            begin
                if (pg_int)
                    pg_seen <= 1'b1;
                if (pg_seen && cycle_tick && pgd_cnt != PGD_LOAD)
                    pgd_cnt <= pgd_cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            power_good_n_out <= 1'b1;
            power_good_n_oe <= 1'b0;
            delayed_power_good_out <= 1'b0;
            delayed_power_good_oe <= 1'b1;
        end
        else if (ce)
        begin
            power_good_n_out <= !pg_int;
            power_good_n_oe <= pg_int;
            delayed_power_good_out <= dpg_int;
            delayed_power_good_oe <= !dpg_int;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ref_mv <= crc_pkg::REF_TOP_MV;
            ref_from_sleep_level <= 1'b0;
            ref_from_boot <= 1'b1;
            slew_select <= crc_pkg::SLEW_IDLE;
            hysteresis_set_reduced <= 1'b0;
        end
        else if (ce)
        begin
            ref_mv <= crc_pkg::REF_TOP_MV - REF_W'(code) * crc_pkg::REF_STEP_MV;
            ref_from_sleep_level <= sleep_act && !code_sleep_mode;
            ref_from_boot <= state != crc_pkg::ST_RUN;
            if (state == crc_pkg::ST_SOFT)
                slew_select <= crc_pkg::SLEW_SOFT;
            else if (!transition)
                slew_select <= crc_pkg::SLEW_IDLE;
            else if (change ? (sleep_act != sleep_q) : last_change_sleep)
                slew_select <= crc_pkg::SLEW_SLEEP;
            else
                slew_select <= crc_pkg::SLEW_CODE;
            hysteresis_set_reduced <= sleep_act;
        end
    end

    // AHB-Lite: zero wait states, always OKAY, one write-steering register
    logic dp_write;
    logic [3:0] dp_addr;
    logic [31:0] rd_word;
    logic addr_ok;

    assign addr_ok = haddr[31:4] == 28'h0000000;

    always_comb
    begin
        rd_word = 32'h00000000;
        if (addr_ok)
        begin
            unique case (haddr[3:0])
                crc_pkg::ADDR_CTRL: rd_word[crc_pkg::CTRL_SW_EN] = sw_enable;
                crc_pkg::ADDR_STATUS:
                begin
                    rd_word[crc_pkg::ST_RUNNING] = switching;
                    rd_word[crc_pkg::ST_PG] = pg_int;
                    rd_word[crc_pkg::ST_DPG] = dpg_int;
                    rd_word[crc_pkg::ST_F_OV] = fault_ov;
                    rd_word[crc_pkg::ST_F_CL] = fault_cl;
                    rd_word[crc_pkg::ST_F_HOT] = fault_hot;
                    rd_word[crc_pkg::ST_CODE_SLP] = code_sleep_mode;
                    rd_word[crc_pkg::ST_SLP_ACT] = sleep_act;
                    rd_word[crc_pkg::ST_CL_BLK] = cl_block;
                    rd_word[crc_pkg::ST_SOFT_ACT] = state == crc_pkg::ST_SOFT;
                end
                crc_pkg::ADDR_REF: rd_word[REF_W-1:0] = ref_mv;
                crc_pkg::ADDR_COUNT:
                begin
                    rd_word[5:0] = cl_count;
                    rd_word[crc_pkg::CNT_BLANK_LSB +: 6] = blank_cnt;
                    rd_word[crc_pkg::CNT_PGD_LSB +: 10] = pgd_cnt;
                end
                default: rd_word = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write <= 1'b0;
            dp_addr <= 4'h0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready)
            begin
                dp_write <= hsel && htrans[1] && hwrite && addr_ok && hsize == 3'h2;
                dp_addr <= haddr[3:0];
                if (hsel && htrans[1] && !hwrite)
                    hrdata <= rd_word;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sw_enable <= crc_pkg::CTRL_SW_EN_RESET;
        else if (ce && dp_write && dp_addr == crc_pkg::ADDR_CTRL)
            sw_enable <= hwdata[crc_pkg::CTRL_SW_EN];
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || !ce);

    sequence s_live;
        supplies_ok && enable_ok;
    endsequence

    sequence s_code_change;
        change && !$past(change);
    endsequence

    lockout_gates_a: assert property (!supplies_ok |=> !high_side_gate && !low_side_gate)
        else $error("gate driven in lockout");
    ov_low_on_a: assert property (s_live ##0 (state == crc_pkg::ST_FAULT && fault_ov) |=> low_side_gate)
        else $error("low gate not held on after over-voltage");
    fault_sticky_a: assert property (state == crc_pkg::ST_FAULT ##1 s_live |-> state == crc_pkg::ST_FAULT)
        else $error("fault left without enable cycle");
    ov_cause_a: assert property ($rose(fault_ov) |-> $past(ov_now))
        else $error("over-voltage latched without cause");
    ov_abs_a: assert property (s_live ##0 (clean[crc_pkg::P_OV_ABS] && switching) |=> fault_ov)
        else $error("absolute over-voltage missed");
    hot_off_a: assert property (s_live ##0 (state == crc_pkg::ST_FAULT && fault_hot) |=> !high_side_gate
        && !low_side_gate)
        else $error("gate driven in thermal fault");
    ref_map_a: assert property (##1 ref_mv == crc_pkg::REF_TOP_MV - REF_W'($past(code)) * crc_pkg::REF_STEP_MV)
        else $error("reference map wrong");
    cl_block_a: assert property (cl_block |=> !high_side_gate)
        else $error("high gate on during current limit");
    ps_low_off_a: assert property (ps_latch && !(state == crc_pkg::ST_FAULT) |=> !low_side_gate)
        else $error("low gate on after zero crossing");
    blank_pg_a: assert property (s_code_change |=> (!power_good_n_oe && !delayed_power_good_out) [*8])
        else $error("power-good not blanked");
    pgd_delay_a: assert property ($rose(delayed_power_good_out) |-> pgd_cnt == PGD_LOAD && pg_seen)
        else $error("delayed power-good early");
    sleep_src_a: assert property (##1 ref_from_sleep_level == ($past(sleep_act) && !$past(code_sleep_mode)))
        else $error("sleep source wrong");
endmodule : crc_top

// ==== hw/crc_pkg.sv ====
// How it works
// - Bad supply holds both gates off.
// - Output above window latches low gate on.
// - Latched faults clear only by power/enable cycle.
// - Window over-voltage latch blocked in soft-start, transitions.
// - Absolute over-voltage arms the latch in every switching state (soft-start, boot, run).
// - Over-temperature latches both gates off unless over-voltage also latched.
// - Reference equals 1708 mV minus 16 per code.
// - Over-current blocks high gate until under-current.
// - Count limit pulses below window, then latch.
// - Limit latch inhibited during soft-start.
// - Zero crossing latches the low gate off.
// - High gate turn-on clears power-save latch.
// - Slew current follows soft-start, code, sleep mode.
// - Any code or sleep change blanks both power-goods.
// - Default mode: sleep takes analog sleep level.
// - Code sleep mode keeps code reference in sleep.
// - Sleep reduces both hysteresis currents.
// - Sleep-source strap sampled at start-up only.
// - Soft-start ramps to boot level before regulation.
// - Delayed power-good follows first power-good by count.
// - Power-good asserts in window, off when disabled.
package crc_pkg;
    typedef enum {ST_OFF, ST_SOFT, ST_BOOT, ST_RUN, ST_FAULT} crc_state_type;
    localparam int CODE_W = 6;
    localparam int REF_W = 11;
    localparam logic [REF_W-1:0] REF_TOP_MV = 11'h6AC;
    localparam logic [REF_W-1:0] REF_STEP_MV = 11'h010;
    localparam int CL_LIMIT = 32;
    localparam int BLANK_CYCLES = 62;
    localparam int PGD_CYCLES = 1007;
    localparam int CLK_PERIOD_NS = 40;
    localparam int BOOT_TIME_NS = 10000;
    localparam int BOOT_CLKS = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int P_SUPPLY_A = 0;
    localparam int P_SUPPLY_D = 1;
    localparam int P_ENABLE = 2;
    localparam int P_OV_WIN = 3;
    localparam int P_OV_ABS = 4;
    localparam int P_UV_WIN = 5;
    localparam int P_IN_WIN = 6;
    localparam int P_HOT = 7;
    localparam int P_OC = 8;
    localparam int P_UC = 9;
    localparam int P_ZC = 10;
    localparam int P_HS_REQ = 11;
    localparam int P_SS_DONE = 12;
    localparam int P_SLEEP = 13;
    localparam int P_STRAP = 14;
    localparam int P_CODE = 15;
    localparam int SYNC_W = 21;
    localparam logic [1:0] SLEW_IDLE = 2'h0;
    localparam logic [1:0] SLEW_SOFT = 2'h1;
    localparam logic [1:0] SLEW_CODE = 2'h2;
    localparam logic [1:0] SLEW_SLEEP = 2'h3;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_REF = 4'h8;
    localparam logic [3:0] ADDR_COUNT = 4'hC;
    localparam int CTRL_SW_EN = 0;
    localparam logic CTRL_SW_EN_RESET = 1'b1;
    localparam int ST_RUNNING = 0;
    localparam int ST_PG = 1;
    localparam int ST_DPG = 2;
    localparam int ST_F_OV = 3;
    localparam int ST_F_CL = 4;
    localparam int ST_F_HOT = 5;
    localparam int ST_CODE_SLP = 6;
    localparam int ST_SLP_ACT = 7;
    localparam int ST_CL_BLK = 8;
    localparam int ST_SOFT_ACT = 9;
    localparam int CNT_BLANK_LSB = 8;
    localparam int CNT_PGD_LSB = 16;
endpackage : crc_pkg

// ==== sim/crc_proc_model.sv ====
`timescale 1ns/10ps
module crc_proc_model (
    // Clock
    input wire logic hclk,
    // Bench requests
    input wire logic [5:0] code_req,
    input wire logic sleep_req,
    // Controller pins
    output logic [5:0] voltage_code,
    output logic sleep_request
);
    // All code bits move at one edge, so no skewed code is seen
    always_ff @(posedge hclk)
    begin
        voltage_code <= code_req;
        sleep_request <= sleep_req;
    end
endmodule : crc_proc_model

// ==== sim/crc_tb_top.sv ====
`timescale 1ns/10ps
// Outputs are looked at on the falling edge, where they have settled, then drives resume on a rising edge
`define C(a, b) begin @(negedge hclk); n_compared++; \
    if ((a) !== (b)) begin err_count++; $display("mismatch %0t %0h", $time, a); end @(posedge hclk); end
module crc_tb_top;
    logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, enable = 1'h0, over_temp = 1'h0, zero_cross = 1'h0;
    logic supply_good_analog = 1'h0, supply_good_driver = 1'h0, fb_over_window = 1'h0, fb_over_abs = 1'h0;
    logic fb_under_window = 1'h0, fb_in_window = 1'h0, over_current = 1'h0, under_current = 1'h0, sleep_req = 1'h0;
    logic hs_request = 1'h0, soft_start_done = 1'h0, sleep_request, hreadyout, hresp, high_side_gate, low_side_gate;
    logic power_good_n_out, power_good_n_oe, delayed_power_good_out, delayed_power_good_oe, ref_from_sleep_level;
    logic ref_from_boot, hysteresis_set_reduced, ce = 1'h1, sleep_level_at_supply = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
    logic [1:0] htrans = 2'h0, slew_select;
    logic [5:0] code_req = 6'h00, voltage_code, codes [3] = '{6'h01, 6'h3F, 6'h20};
    logic [10:0] ref_mv;
    int err_count = 0, n_compared = 0;
    // Small counts keep the run short; expectations use 4, 4 and 8
    crc_top #(.CL_LIMIT(4), .BLANK_CYCLES(4), .PGD_CYCLES(8)) u_dut (.hsel(1'h1), .hsize(3'h2),
        .hready(hreadyout), .*);
    crc_proc_model u_proc (.*);
    always #20 hclk = ~hclk;
    initial
    begin
        w(5000);
        err_count++;
        wrap_up();
    end
    task automatic w(input int n);
        repeat (n) @(posedge hclk);
    endtask : w
    task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] v);
        {haddr, hwrite, htrans} <= {a, wr, 2'h2};
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        {htrans, hwdata} <= {2'h0, v};
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rdata = hrdata;
    endtask : bus
    task automatic sw(input int n);
        repeat (2 * n)
        begin
            hs_request <= ~hs_request;
            w(6);
        end
    endtask : sw
    task automatic up;
        {supply_good_analog, supply_good_driver, enable, fb_in_window, soft_start_done, hs_request} <= 6'h3C;
        w(10);
        `C(slew_select, crc_pkg::SLEW_SOFT)
        soft_start_done <= 1'h1;
        // Switching during boot lets any blanking left from before the restart run out
        sw(4);
        w(222);
        `C({ref_from_boot, power_good_n_oe}, 2'h1)
        $display("test startup done");
    endtask : up
    task automatic dn;
        {enable, fb_over_window, fb_over_abs, over_temp, fb_under_window, over_current} <= 6'h00;
        w(8);
        `C({high_side_gate, low_side_gate, power_good_n_oe}, 3'h0)
        up();
    endtask : dn
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    initial
    begin
        w(8);
        hresetn <= 1'h1;
        w(2);
        bus(32'h8, 1'h0, 32'h0);
        `C(rdata, 32'h6AC)
        bus(32'h10, 1'h0, 32'h0);
        `C({rdata, hresp}, 33'h0)
        {hs_request, supply_good_analog, enable} <= 3'h7;
        w(10);
        `C({high_side_gate, low_side_gate}, 2'h0)
        up();
        sw(6);
        `C(delayed_power_good_oe, 1'h1)
        sw(3);
        `C(delayed_power_good_oe, 1'h0)
        zero_cross <= 1'h1;
        w(6);
        `C(low_side_gate, 1'h0)
        zero_cross <= 1'h0;
        sw(1);
        `C(low_side_gate, 1'h1)
        over_current <= 1'h1;
        w(6);
        hs_request <= 1'h1;
        w(6);
        `C(high_side_gate, 1'h0)
        {over_current, under_current} <= 2'h1;
        w(6);
        `C(high_side_gate, 1'h1)
        {under_current, hs_request} <= 2'h0;
        foreach (codes[i])
        begin
            code_req <= codes[i];
            w(6);
            `C({power_good_n_oe, delayed_power_good_oe, slew_select}, {2'h1, crc_pkg::SLEW_CODE})
            `C(ref_mv, 11'h6AC - 11'(codes[i]) * 11'h010)
            sw(5);
        end
        sleep_req <= 1'h1;
        w(6);
        `C({ref_from_sleep_level, hysteresis_set_reduced, slew_select}, {2'h3, crc_pkg::SLEW_SLEEP})
        sleep_req <= 1'h0;
        fb_over_window <= 1'h1;
        w(8);
        bus(32'h4, 1'h0, 32'h0);
        `C(rdata[3], 1'h0)
        fb_over_abs <= 1'h1;
        w(8);
        `C({high_side_gate, low_side_gate}, 2'h1)
        bus(32'h0, 1'h1, 32'h0);
        bus(32'h0, 1'h1, 32'h1);
        dn();
        {fb_under_window, fb_in_window} <= 2'h2;
        repeat (8)
        begin
            over_current <= ~over_current;
            w(6);
        end
        bus(32'h4, 1'h0, 32'h0);
        `C({rdata[4], high_side_gate}, 2'h2)
        sleep_level_at_supply <= 1'h1;
        dn();
        sleep_req <= 1'h1;
        w(6);
        `C({ref_from_sleep_level, hysteresis_set_reduced}, 2'h1)
        {ce, over_temp} <= 2'h1;
        w(8);
        `C({high_side_gate, low_side_gate}, 2'h1)
        ce <= 1'h1;
        w(8);
        `C({high_side_gate, low_side_gate}, 2'h0)
        $display("test faults done");
        wrap_up();
    end
endmodule : crc_tb_top
